// [src/pbm_defines.svh]
// Register indices, field positions, reset values and timing counts of the PHY basic registers
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define PBM_IDX_CONTROL 5'h00
`define PBM_IDX_STATUS 5'h01
`define PBM_IDX_IDENT_UPPER 5'h02
`define PBM_IDX_IDENT_LOWER 5'h03
`define PBM_IDX_ADVERTISE 5'h04

// ****************************************************************
// Control field positions
// ****************************************************************
`define PBM_CTRL_SRST_BIT 15
`define PBM_CTRL_LOOP_BIT 14
`define PBM_CTRL_SPEED_BIT 13
`define PBM_CTRL_AN_EN_BIT 12
`define PBM_CTRL_PDOWN_BIT 11
`define PBM_CTRL_RESTART_BIT 9
`define PBM_CTRL_DUPLEX_BIT 8
`define PBM_CTRL_COLTEST_BIT 7

// ****************************************************************
// Status field positions and fixed capability value
// ****************************************************************
`define PBM_STAT_AN_DONE_BIT 5
`define PBM_STAT_RFAULT_BIT 4
`define PBM_STAT_LINK_BIT 2
`define PBM_STAT_JABBER_BIT 1
`define PBM_STAT_CAPS 16'h7809

// ****************************************************************
// Advertisement fields and reset values
// ****************************************************************
`define PBM_ADV_RFAULT_BIT 13
`define PBM_ADV_PAUSE_HI 11
`define PBM_ADV_PAUSE_LO 10
`define PBM_ADV_ABIL_HI 8
`define PBM_ADV_ABIL_LO 5
`define PBM_ADV_SEL_HI 4
`define PBM_ADV_SEL_LO 0
`define PBM_ADV_PAUSE_RESET 2'h0
`define PBM_ADV_SEL_RESET 5'h01
`define PBM_ADV_100HD_RESET 1'h1

// ****************************************************************
// Timing
// ****************************************************************
`define PBM_CLK_PERIOD_NS 4
`define PBM_SRST_TIME_NS 400
`define PBM_SRST_CYCLES ((`PBM_SRST_TIME_NS + `PBM_CLK_PERIOD_NS - 1) / `PBM_CLK_PERIOD_NS)
`define PBM_SYNC_STAGES 2

`endif

// [src/pbm_latch_bit.sv]
// Status flag that latches an event until the status register is read
module pbm_latch_bit #(
    parameter bit LATCH_HIGH = 1'b1
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic cond_in,
    input wire logic clear_in,
    output logic flag_out
);

    // ****************************************************************
    // Latch
    // ****************************************************************
    logic event_seen;
    logic flag_reg;
    logic flag_next;

    assign event_seen = LATCH_HIGH ? cond_in : ~cond_in;

    // Event beats the read-clear in the same cycle, so nothing is lost
    always_comb begin
        flag_next = flag_reg;
        if (event_seen) begin
            flag_next = LATCH_HIGH;
        end else if (clear_in) begin
            flag_next = ~LATCH_HIGH;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;

endmodule : pbm_latch_bit

// [src/pbm_pkg.sv]
// Types shared by the PHY basic management register block
package pbm_pkg;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        PBM_ST_BOOT = 3'b001,
        PBM_ST_IDLE = 3'b010,
        PBM_ST_SRST = 3'b100
    } pbm_state_t;

    // ****************************************************************
    // Pause advertisement encoding
    // ****************************************************************
    typedef enum logic [1:0] {
        PBM_PAUSE_NONE = 2'h0,
        PBM_PAUSE_SYM = 2'h1,
        PBM_PAUSE_ASYM = 2'h2,
        PBM_PAUSE_BOTH = 2'h3
    } pbm_pause_t;

endpackage : pbm_pkg

// [src/pbm_regs.sv]
// PHY basic control, status, identifier and advertisement registers
`include "pbm_defines.svh"

module pbm_regs
    import pbm_pkg::*;
#(
    // Arbitrary neutral identity values
    parameter logic [15:0] OUI_MID = 16'h1234,
    parameter logic [5:0] OUI_LOW = 6'h15,
    parameter logic [5:0] MODEL_NUM = 6'h2a,
    parameter logic [3:0] REVISION_NUM = 4'h1,
    parameter int SRST_CYCLES = `PBM_SRST_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic mgmt_req_in,
    input wire logic mgmt_write_in,
    input wire logic [4:0] mgmt_index_in,
    input wire logic [15:0] mgmt_wdata_in,
    output logic mgmt_ready_out,
    output logic mgmt_ack_out,
    output logic [15:0] mgmt_rdata_out,
    input wire logic speed_strap_in,
    input wire logic link_up_in,
    input wire logic remote_fault_in,
    input wire logic jabber_in,
    input wire logic an_done_in,
    input wire logic [1:0] partner_pause_in,
    output logic soft_reset_out,
    output logic loopback_out,
    output logic an_enable_out,
    output logic an_restart_out,
    output logic speed_100_out,
    output logic full_duplex_out,
    output logic power_down_out,
    output logic col_test_out,
    output logic [15:0] adv_word_out,
    output logic pause_sym_out,
    output logic pause_asym_out
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int SYNC_W = 7;
    localparam int CNT_W = $clog2(SRST_CYCLES + 1);

    if (SRST_CYCLES < `PBM_SYNC_STAGES) begin : g_bad_srst
        $error("SRST_CYCLES must be at least two");
    end

    function automatic logic hits(input logic req, input logic [4:0] idx,
                                  input logic [4:0] target);
        hits = req && (idx == target);
    endfunction : hits

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    assign pins_raw = {partner_pause_in, an_done_in, jabber_in, remote_fault_in,
                       link_up_in, speed_strap_in};
    // First stage feeds only the second stage
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clock_in or posedge reset_in) begin
                if (reset_in) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pins_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic strap_s, link_s, rfault_s, jabber_s, an_done_s;
    logic [1:0] lp_pause_s;
    assign {lp_pause_s, an_done_s, jabber_s, rfault_s, link_s, strap_s} = sync2_reg;

    // ****************************************************************
    // Access decode and sequencer: boot strap capture and soft reset
    // ****************************************************************
    pbm_state_t state_reg;
    logic take, wr_ctrl, wr_adv, rd_status, srst_req, restart_req;
    // Requests are only taken while idle
    assign take = mgmt_req_in && (state_reg == PBM_ST_IDLE);
    assign wr_ctrl = hits(take & mgmt_write_in, mgmt_index_in, `PBM_IDX_CONTROL);
    assign wr_adv = hits(take & mgmt_write_in, mgmt_index_in, `PBM_IDX_ADVERTISE);
    assign rd_status = hits(take & ~mgmt_write_in, mgmt_index_in, `PBM_IDX_STATUS);
    assign srst_req = wr_ctrl && mgmt_wdata_in[`PBM_CTRL_SRST_BIT];
    assign restart_req = wr_ctrl && !srst_req && mgmt_wdata_in[`PBM_CTRL_RESTART_BIT];
    logic [CNT_W-1:0] cnt_reg;
    logic load_defaults;

    // Strap is taken only after the synchroniser has filled
    assign load_defaults = (state_reg == PBM_ST_BOOT &&
                            cnt_reg == CNT_W'(`PBM_SYNC_STAGES)) ||
                           (state_reg == PBM_ST_SRST && cnt_reg == CNT_W'(1));

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= PBM_ST_BOOT;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                PBM_ST_BOOT: begin
                    if (cnt_reg == CNT_W'(`PBM_SYNC_STAGES)) begin
                        state_reg <= PBM_ST_IDLE;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
                PBM_ST_IDLE: begin
                    if (srst_req) begin
                        state_reg <= PBM_ST_SRST;
                        cnt_reg <= CNT_W'(SRST_CYCLES);
                    end
                end
                PBM_ST_SRST: begin
                    if (cnt_reg == CNT_W'(1)) begin
                        state_reg <= PBM_ST_IDLE;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
                default: begin
                    state_reg <= PBM_ST_BOOT;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Control and advertisement registers
    // ****************************************************************
    logic ctrl_loop_reg, ctrl_speed_reg, ctrl_an_en_reg, ctrl_pdown_reg;
    logic ctrl_restart_reg, ctrl_duplex_reg, ctrl_coltest_reg;
    // Other bits written with the reset bit are dropped; defaults win
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_loop_reg <= 1'b0;
            ctrl_speed_reg <= 1'b0;
            ctrl_an_en_reg <= 1'b0;
            ctrl_pdown_reg <= 1'b0;
            ctrl_duplex_reg <= 1'b0;
            ctrl_coltest_reg <= 1'b0;
        end else if (load_defaults) begin
            ctrl_loop_reg <= 1'b0;
            ctrl_speed_reg <= strap_s;
            ctrl_an_en_reg <= strap_s;
            ctrl_pdown_reg <= 1'b0;
            ctrl_duplex_reg <= 1'b0;
            ctrl_coltest_reg <= 1'b0;
        end else if (wr_ctrl && !srst_req) begin
            ctrl_loop_reg <= mgmt_wdata_in[`PBM_CTRL_LOOP_BIT];
            ctrl_speed_reg <= mgmt_wdata_in[`PBM_CTRL_SPEED_BIT];
            ctrl_an_en_reg <= mgmt_wdata_in[`PBM_CTRL_AN_EN_BIT];
            ctrl_pdown_reg <= mgmt_wdata_in[`PBM_CTRL_PDOWN_BIT];
            ctrl_duplex_reg <= mgmt_wdata_in[`PBM_CTRL_DUPLEX_BIT];
            ctrl_coltest_reg <= mgmt_wdata_in[`PBM_CTRL_COLTEST_BIT];
        end
    end
    // Restart bit reads one for the single cycle after the write
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_restart_reg <= 1'b0;
        end else begin
            ctrl_restart_reg <= restart_req;
        end
    end

    logic adv_rfault_reg;
    logic [1:0] adv_pause_reg;
    logic [3:0] adv_abil_reg;
    logic [4:0] adv_sel_reg;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            adv_rfault_reg <= 1'b0;
            adv_pause_reg <= `PBM_ADV_PAUSE_RESET;
            adv_abil_reg <= 4'h0;
            adv_sel_reg <= `PBM_ADV_SEL_RESET;
        end else if (load_defaults) begin
            adv_rfault_reg <= 1'b0;
            adv_pause_reg <= `PBM_ADV_PAUSE_RESET;
            adv_abil_reg <= {strap_s, `PBM_ADV_100HD_RESET, 1'b1, 1'b1};
            adv_sel_reg <= `PBM_ADV_SEL_RESET;
        end else if (wr_adv) begin
            adv_rfault_reg <= mgmt_wdata_in[`PBM_ADV_RFAULT_BIT];
            adv_pause_reg <= mgmt_wdata_in[`PBM_ADV_PAUSE_HI:`PBM_ADV_PAUSE_LO];
            adv_abil_reg <= mgmt_wdata_in[`PBM_ADV_ABIL_HI:`PBM_ADV_ABIL_LO];
            adv_sel_reg <= mgmt_wdata_in[`PBM_ADV_SEL_HI:`PBM_ADV_SEL_LO];
        end
    end

    // ****************************************************************
    // Latched status flags and negotiation
    // ****************************************************************
    logic rfault_flag, link_flag, jabber_flag;

    pbm_latch_bit #(.LATCH_HIGH(1'b1)) u_rfault (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .cond_in(rfault_s),
        .clear_in(rd_status),
        .flag_out(rfault_flag)
    );

    pbm_latch_bit #(.LATCH_HIGH(1'b0)) u_link (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .cond_in(link_s),
        .clear_in(rd_status),
        .flag_out(link_flag)
    );

    pbm_latch_bit #(.LATCH_HIGH(1'b1)) u_jabber (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .cond_in(jabber_s),
        .clear_in(rd_status),
        .flag_out(jabber_flag)
    );

    logic an_cmp, res_sym, an_done_prev_reg, pause_sym_reg, pause_asym_reg;
    // Complete only counts while negotiation is on and the PHY is awake
    assign an_cmp = an_done_s && ctrl_an_en_reg && !ctrl_pdown_reg;
    assign res_sym = adv_pause_reg[0] && lp_pause_s[0];

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            an_done_prev_reg <= 1'b0;
            pause_sym_reg <= 1'b0;
            pause_asym_reg <= 1'b0;
        end else begin
            an_done_prev_reg <= an_cmp;
            if (!an_cmp || state_reg != PBM_ST_IDLE) begin
                pause_sym_reg <= 1'b0;
                pause_asym_reg <= 1'b0;
            end else if (!an_done_prev_reg) begin
                // Symmetric takes priority, never both at once
                pause_sym_reg <= res_sym;
                pause_asym_reg <= !res_sym && adv_pause_reg[1] && lp_pause_s[1];
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [15:0] ctrl_word, stat_word, adv_word, rd_word;
    always_comb begin
        ctrl_word = 16'h0000; // reserved bits zero
        ctrl_word[`PBM_CTRL_SRST_BIT] = (state_reg == PBM_ST_SRST);
        ctrl_word[`PBM_CTRL_LOOP_BIT] = ctrl_loop_reg;
        ctrl_word[`PBM_CTRL_SPEED_BIT] = ctrl_speed_reg;
        ctrl_word[`PBM_CTRL_AN_EN_BIT] = ctrl_an_en_reg;
        ctrl_word[`PBM_CTRL_PDOWN_BIT] = ctrl_pdown_reg;
        ctrl_word[`PBM_CTRL_RESTART_BIT] = ctrl_restart_reg;
        ctrl_word[`PBM_CTRL_DUPLEX_BIT] = ctrl_duplex_reg;
        ctrl_word[`PBM_CTRL_COLTEST_BIT] = ctrl_coltest_reg;
    end

    always_comb begin
        stat_word = `PBM_STAT_CAPS;
        stat_word[`PBM_STAT_AN_DONE_BIT] = an_cmp;
        stat_word[`PBM_STAT_RFAULT_BIT] = rfault_flag;
        stat_word[`PBM_STAT_LINK_BIT] = link_flag;
        stat_word[`PBM_STAT_JABBER_BIT] = jabber_flag;
    end

    always_comb begin
        adv_word = 16'h0000;
        adv_word[`PBM_ADV_RFAULT_BIT] = adv_rfault_reg;
        adv_word[`PBM_ADV_PAUSE_HI:`PBM_ADV_PAUSE_LO] = adv_pause_reg;
        adv_word[`PBM_ADV_ABIL_HI:`PBM_ADV_ABIL_LO] = adv_abil_reg;
        adv_word[`PBM_ADV_SEL_HI:`PBM_ADV_SEL_LO] = adv_sel_reg;
    end

    // Unmapped indices read zero and ignore writes
    always_comb begin
        case (mgmt_index_in)
            `PBM_IDX_CONTROL: rd_word = ctrl_word;
            `PBM_IDX_STATUS: rd_word = stat_word;
            `PBM_IDX_IDENT_UPPER: rd_word = OUI_MID;
            `PBM_IDX_IDENT_LOWER: rd_word = {OUI_LOW, MODEL_NUM, REVISION_NUM};
            `PBM_IDX_ADVERTISE: rd_word = adv_word;
            default: rd_word = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            mgmt_ack_out <= 1'b0;
            mgmt_rdata_out <= 16'h0000;
        end else begin
            mgmt_ack_out <= take;
            if (take && !mgmt_write_in) begin
                mgmt_rdata_out <= rd_word;
            end
        end
    end
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            mgmt_ready_out <= 1'b0;
            soft_reset_out <= 1'b0;
            loopback_out <= 1'b0;
            an_enable_out <= 1'b0;
            an_restart_out <= 1'b0;
            speed_100_out <= 1'b0;
            full_duplex_out <= 1'b0;
            power_down_out <= 1'b0;
            col_test_out <= 1'b0;
            adv_word_out <= 16'h0000;
            pause_sym_out <= 1'b0;
            pause_asym_out <= 1'b0;
        end else begin
            mgmt_ready_out <= (state_reg == PBM_ST_IDLE) && !srst_req;
            soft_reset_out <= (state_reg == PBM_ST_SRST) || srst_req;
            loopback_out <= ctrl_loop_reg;
            an_enable_out <= ctrl_an_en_reg;
            an_restart_out <= restart_req && mgmt_wdata_in[`PBM_CTRL_AN_EN_BIT];
            speed_100_out <= ctrl_speed_reg && !ctrl_an_en_reg;
            full_duplex_out <= ctrl_duplex_reg && !ctrl_an_en_reg;
            power_down_out <= ctrl_pdown_reg;
            col_test_out <= ctrl_coltest_reg;
            adv_word_out <= adv_word;
            pause_sym_out <= pause_sym_reg;
            pause_asym_out <= pause_asym_reg;
        end
    end

endmodule : pbm_regs

// [verification/pbm_host_model.sv]
// Management master standing in for the host indirect access logic
module pbm_host_model (
    input wire logic clock_in,
    input wire logic ready_in,
    input wire logic ack_in,
    input wire logic [15:0] rdata_in,
    output logic req_out,
    output logic write_out,
    output logic [4:0] index_out,
    output logic [15:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_out = 1'b0;
        write_out = 1'b0;
        index_out = 5'h1f;
        wdata_out = 16'hffff;
    end
    // Held until the taking edge; lines scrambled after so stale data is never reused
    task automatic xfer(input logic w, input logic [4:0] i, input logic [15:0] d,
                        output logic [15:0] q, output logic a);
        @(negedge clock_in);
        for (int n = 0; n < 300 && ready_in !== 1'b1; n++) @(negedge clock_in);
        req_out = 1'b1;
        write_out = w;
        index_out = i;
        wdata_out = d;
        @(negedge clock_in);
        a = ack_in;
        q = rdata_in;
        req_out = 1'b0;
        index_out = ~i;
        wdata_out = ~d;
    endtask : xfer
endmodule : pbm_host_model

// [verification/pbm_regs_checker.sv]
// Assertion checker for the PHY basic management registers
module pbm_regs_checker #(
    parameter int SRST_CYCLES = 100
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic mgmt_req_in,
    input wire logic mgmt_write_in,
    input wire logic [4:0] mgmt_index_in,
    input wire logic [15:0] mgmt_wdata_in,
    input wire logic mgmt_ack_out,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic soft_reset_out,
    input wire logic an_enable_out,
    input wire logic an_restart_out,
    input wire logic speed_100_out,
    input wire logic full_duplex_out,
    input wire logic pause_sym_out,
    input wire logic pause_asym_out
);
    localparam int SR_MAX = SRST_CYCLES + 3;
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    chk_ack_cause: assert property (mgmt_ack_out |-> $past(mgmt_req_in))
        else $error("ack without request");
    chk_sr_length: assert property ($rose(soft_reset_out) |-> soft_reset_out[*3] ##[1:SR_MAX] !soft_reset_out)
        else $error("soft reset length");
    chk_speed_forced: assert property (speed_100_out |-> !an_enable_out)
        else $error("speed forced under negotiation");
    chk_duplex_forced: assert property (full_duplex_out |-> !an_enable_out)
        else $error("duplex forced under negotiation");
    chk_pause_single: assert property (!(pause_sym_out && pause_asym_out))
        else $error("both pause kinds");
    chk_restart_cause: assert property (an_restart_out |-> $past(mgmt_write_in) && $past(mgmt_wdata_in[9]))
        else $error("restart without write");
    chk_rdata_hold: assert property (!mgmt_ack_out |-> $stable(mgmt_rdata_out))
        else $error("read data moved");
    chk_caps_read: assert property (mgmt_ack_out && !$past(mgmt_write_in) && $past(mgmt_index_in) == 5'h01
        |-> (mgmt_rdata_out & 16'hffc9) == 16'h7809)
        else $error("capability bits");
endmodule : pbm_regs_checker

bind pbm_regs pbm_regs_checker #(.SRST_CYCLES(SRST_CYCLES)) i_chk (.*);

// [verification/tb_top.sv]
// Self-checking bench of the PHY basic management registers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic mgmt_req_in, mgmt_write_in, mgmt_ready_out, mgmt_ack_out;
    logic [4:0] mgmt_index_in;
    logic [15:0] mgmt_wdata_in, mgmt_rdata_out, adv_word_out;
    logic speed_strap_in = 1'b1;
    logic link_up_in = 1'b0;
    logic remote_fault_in = 1'b0;
    logic jabber_in = 1'b0;
    logic an_done_in = 1'b0;
    logic [1:0] partner_pause_in = 2'h3;
    logic soft_reset_out, loopback_out, an_enable_out, an_restart_out, speed_100_out;
    logic full_duplex_out, power_down_out, col_test_out, pause_sym_out, pause_asym_out;
    int n_errors = 0;
    int tests_run = 0;
    always #2 clock_in = ~clock_in;
    // Short soft reset keeps the run brief
    pbm_regs #(.SRST_CYCLES(4)) i_dut (.*);
    pbm_host_model i_host (.clock_in(clock_in), .ready_in(mgmt_ready_out), .ack_in(mgmt_ack_out),
        .rdata_in(mgmt_rdata_out), .req_out(mgmt_req_in), .write_out(mgmt_write_in),
        .index_out(mgmt_index_in), .wdata_out(mgmt_wdata_in));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d);
        logic [15:0] q;
        logic a;
        i_host.xfer(w, i, d, q, a);
        check("ack", 16'h0001, {15'h0, a});
        if (!w) check($sformatf("index %0d", i), d, q);
    endtask : acc
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (12) @(negedge clock_in);
        reset_in = 1'b0;
        acc(0, 5'h00, 16'h3000);
        acc(0, 5'h01, 16'h7809);
        acc(0, 5'h02, 16'h1234);
        acc(0, 5'h03, 16'h56a1);
        acc(0, 5'h04, 16'h01e1);
        acc(0, 5'h07, 16'h0000);
        $display("test defaults done");
        acc(1, 5'h00, 16'h6980);
        acc(0, 5'h00, 16'h6980);
        check("modes", 16'h003e, {10'h0, loopback_out, power_down_out, full_duplex_out,
            col_test_out, speed_100_out, an_enable_out});
        acc(1, 5'h01, 16'h0000);
        for (int p = 0; p < 4; p++) begin
            acc(1, 5'h04, {4'h0, p[1:0], 10'h0e1});
            acc(0, 5'h04, {4'h0, p[1:0], 10'h0e1});
        end
        acc(1, 5'h04, 16'h3ce1);
        acc(0, 5'h04, 16'h2ce1);
        check("adv", 16'h2ce1, adv_word_out);
        $display("test writes done");
        acc(1, 5'h00, 16'h1000);
        an_done_in = 1'b1;
        acc(1, 5'h00, 16'h1200);
        check("restart", 16'h0001, {15'h0, an_restart_out});
        acc(0, 5'h00, 16'h1000);
        acc(1, 5'h00, 16'h1800);
        acc(0, 5'h01, 16'h7809);
        acc(1, 5'h00, 16'h1000);
        repeat (5) @(negedge clock_in);
        acc(0, 5'h01, 16'h7829);
        check("pause", 16'h0002, {14'h0, pause_sym_out, pause_asym_out});
        $display("test negotiation done");
        remote_fault_in = 1'b1;
        jabber_in = 1'b1;
        link_up_in = 1'b1;
        repeat (4) @(negedge clock_in);
        remote_fault_in = 1'b0;
        jabber_in = 1'b0;
        repeat (4) @(negedge clock_in);
        acc(0, 5'h01, 16'h783b);
        acc(0, 5'h01, 16'h782d);
        link_up_in = 1'b0;
        repeat (4) @(negedge clock_in);
        link_up_in = 1'b1;
        repeat (4) @(negedge clock_in);
        acc(0, 5'h01, 16'h7829);
        $display("test latches done");
        speed_strap_in = 1'b0;
        repeat (4) @(negedge clock_in);
        acc(1, 5'h00, 16'h8000);
        check("soft reset", 16'h0001, {15'h0, soft_reset_out});
        acc(0, 5'h00, 16'h0000);
        acc(0, 5'h04, 16'h00e1);
        $display("test soft reset done");
        test_done();
    end
    // Whole run is well under 1 us of traffic; a hang stops long before the cycle budget
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule : tb_top
